//--- dv/srs_chk.sv
// Port-level assertions for the speed reference selector
`timescale 1ns/10ps
module srs_chk (
  input wire logic                   clk_sys_i,
  input wire logic                   nrst_i,
  input wire srs_pkg::srs_contacts_t contacts_i,
  input wire srs_pkg::srs_am_mode_t  am_mode_i,
  input wire logic                   remote_i,
  input wire logic                   three_wire_i,
  input wire logic                   enter_key_i,
  input wire logic [9:0]             freq_level_i,
  input wire logic                   freq_ofs_span_i,
  input wire srs_pkg::srs_ind_t      coll1_fn_i,
  input wire srs_pkg::srs_src_t      ref_src_o,
  input wire logic [9:0]             mop_setpoint_o,
  input wire srs_pkg::srs_status_t   status_o,
  input wire logic [9:0]             frequency_analog_out_o,
  input wire logic                   relay_contact_one_o,
  input wire logic                   relay_contact_two_o,
  input wire logic                   collector_status_out_1_o
);
  // ****************************************
  // Properties
  // ****************************************
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_relay; relay_contact_two_o == !relay_contact_one_o; endproperty
  a_relay: assert property (p_relay)
    else $error("relay terminals not complementary");
  property p_freq; $past(nrst_i) |-> frequency_analog_out_o == ($past(freq_ofs_span_i) ?
    10'h0CD + 10'((20'($past(freq_level_i)) * 20'h332) >> 10) : $past(freq_level_i));
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency output code wrong");
  property p_coll; $rose(status_o.running) && coll1_fn_i == srs_pkg::SRS_IND_RUN
    |-> ##[0:1] collector_status_out_1_o; endproperty
  a_coll: assert property (p_coll)
    else $error("collector does not show running");
  property p_up; $past(nrst_i) && mop_setpoint_o > $past(mop_setpoint_o)
    |-> status_o.running || $past(status_o.running, 2); endproperty
  a_up: assert property (p_up)
    else $error("setpoint rose while stopped");
  property p_step; $past(nrst_i) && $changed(mop_setpoint_o) |-> (mop_setpoint_o -
    $past(mop_setpoint_o) == 10'h001 || $past(mop_setpoint_o) - mop_setpoint_o == 10'h001)
    ##1 $stable(mop_setpoint_o); endproperty
  a_step: assert property (p_step)
    else $error("setpoint step not one code");
  property p_follow; ref_src_o != srs_pkg::SRS_SRC_KEYPAD
    |-> status_o.auto_state && status_o.follow_auto; endproperty
  a_follow: assert property (p_follow)
    else $error("reference followed outside auto");
  // Bound suits the short debounce used in the bench only
  property p_stop; (remote_i && !three_wire_i && !contacts_i.run_stop) [*3]
    |-> ##[0:12] !status_o.running; endproperty
  a_stop: assert property (p_stop)
    else $error("two-wire open did not stop");
  property p_key; !remote_i && am_mode_i != srs_pkg::SRS_AM_OFF
    && $changed(status_o.auto_state) |-> $past(enter_key_i, 2); endproperty
  a_key: assert property (p_key)
    else $error("auto state changed without enter");
endmodule

bind srs_top srs_chk u_chk (.clk_sys_i, .nrst_i, .contacts_i, .am_mode_i, .remote_i,
  .three_wire_i, .enter_key_i, .freq_level_i, .freq_ofs_span_i, .coll1_fn_i, .ref_src_o,
  .mop_setpoint_o, .status_o, .frequency_analog_out_o, .relay_contact_one_o,
  .relay_contact_two_o, .collector_status_out_1_o);

//--- dv/srs_contact_model.sv
// Contact closure source for the selector bench, with chatter on every change
`timescale 1ns/10ps
module srs_contact_model (
  input  wire logic              clk_sys_i,
  input  wire logic [4:0]        cmd_i,
  output srs_pkg::srs_contacts_t contacts_o
);
  logic [4:0] tgt = 5'h00;
  logic [4:0] old = 5'h00;
  logic [1:0] ph  = 2'h3;

  // ****************************************
  // Bounce
  // ****************************************
  // A real contact chatters once; the glitch is shorter than the filter
  always @(negedge clk_sys_i)
  begin
    if (cmd_i != tgt)
    begin
      old <= tgt;
      tgt <= cmd_i;
      ph  <= 2'h0;
    end
    else if (ph != 2'h3)
      ph <= ph + 2'h1;
  end

  // Each commanded level is held until the bench asks for another
  assign contacts_o = (ph == 2'h1) ? old : tgt;
endmodule

//--- dv/tb_speed_reference_selector.sv
// Self-checking bench for the speed reference selector
`timescale 1ns/10ps
module tb_speed_reference_selector;
  srs_pkg::srs_contacts_t contacts_i;
  srs_pkg::srs_sel_cfg_t  sel_cfg_i  = '0;
  srs_pkg::srs_am_mode_t  am_mode_i  = srs_pkg::SRS_AM_OFF;
  srs_pkg::srs_ind_t      relay_fn_i = srs_pkg::SRS_IND_RUN;
  srs_pkg::srs_ind_t      coll1_fn_i = srs_pkg::SRS_IND_RUN;
  srs_pkg::srs_ind_t      coll2_fn_i = srs_pkg::SRS_IND_AUTO;
  srs_pkg::srs_src_t      ref_src_o;
  srs_pkg::srs_status_t   status_o;
  logic clk_sys_i = 1'h0, nrst_i = 1'h0, remote_i = 1'h0, three_wire_i = 1'h0;
  logic am_key_i = 1'h0, enter_key_i = 1'h0, kp_start_i = 1'h0, kp_stop_i = 1'h0;
  logic freq_ofs_span_i = 1'h1, load_ofs_span_i = 1'h0;
  logic [9:0] freq_level_i = 10'h200, load_level_i = 10'h3FF, v;
  logic [9:0] mop_setpoint_o, frequency_analog_out_o, load_analog_out_o;
  logic relay_contact_one_o, relay_contact_two_o;
  logic collector_status_out_1_o, collector_status_out_2_o;
  logic [4:0] cmd = 5'h00;
  int n_errors = 0, comparisons = 0, cyc = 0;
  // Entries: select config, closed inputs a/b/c, expected source code
  logic [14:0] tv [13] = '{15'h14E1, 15'h14F2, 15'h14FD, 15'h14C0, 15'h36E3, 15'h36D4,
    15'h36CD, 15'h36F6, 15'h36DE, 15'h36EE, 15'h36FD, 15'h008A, 15'h14C0};

  // Short counts keep every wait in the tens of cycles
  srs_top #(.DEB_CYC(4), .AM_CYC(20), .STEP_CYC(3)) dut (.clk_sys_i, .nrst_i, .contacts_i,
    .sel_cfg_i, .am_mode_i, .remote_i, .three_wire_i, .am_key_i, .enter_key_i, .kp_start_i,
    .kp_stop_i, .freq_level_i, .load_level_i, .freq_ofs_span_i, .load_ofs_span_i,
    .relay_fn_i, .coll1_fn_i, .coll2_fn_i, .ref_src_o, .mop_setpoint_o, .status_o,
    .frequency_analog_out_o, .load_analog_out_o, .relay_contact_one_o, .relay_contact_two_o,
    .collector_status_out_1_o, .collector_status_out_2_o);
  srs_contact_model u_contacts (.clk_sys_i, .cmd_i(cmd), .contacts_o(contacts_i));

  // Clock and hang guard
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic tap(ref logic k);
    @(negedge clk_sys_i) k = 1'h1;
    @(negedge clk_sys_i) k = 1'h0;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic confirm(input int gap);
    tap(am_key_i);
    wt(gap);
    tap(enter_key_i);
    wt(4);
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  // Reference choice runs in remote with select-driven auto state
  initial
  begin
    wt(12);
    nrst_i = 1'h1;
    wt(1);
    chk("relay2", 10'h001, 10'(relay_contact_two_o));
    chk("freq", 10'h266, frequency_analog_out_o);
    chk("load", 10'h3FF, load_analog_out_o);
    remote_i = 1'h1;
    foreach (tv[i])
    begin
      sel_cfg_i = tv[i][14:6];
      cmd = {2'h0, tv[i][5:3]};
      wt(20);
      chk("src", 10'(tv[i][2:0]), 10'(ref_src_o));
      chk("auto", 10'(tv[i][5:3] != 3'h0), 10'(status_o.auto_state));
    end
    sel_cfg_i = 9'h006;
    cmd = 5'h18;
    wt(20);
    chk("run", 10'h001, 10'(status_o.running));
    chk("relay1", 10'h001, 10'(relay_contact_one_o));
    chk("relay2", 10'h000, 10'(relay_contact_two_o));
    chk("coll1", 10'h001, 10'(collector_status_out_1_o));
    cmd = 5'h08;
    wt(20);
    chk("run", 10'h000, 10'(status_o.running));
    cmd = 5'h11;
    wt(20);
    chk("rev", 10'h003, 10'({status_o.running, status_o.reverse}));
    cmd = 5'h00;
    wt(20);
    three_wire_i = 1'h1;
    cmd = 5'h18;
    wt(20);
    cmd = 5'h10;
    wt(20);
    chk("latch", 10'h001, 10'(status_o.running));
    cmd = 5'h00;
    wt(20);
    cmd = 5'h10;
    wt(20);
    chk("latch", 10'h000, 10'(status_o.running));
    remote_i = 1'h0;
    three_wire_i = 1'h0;
    cmd = 5'h18;
    wt(20);
    chk("local", 10'h000, 10'(status_o.running));
    sel_cfg_i = 9'h128;
    tap(kp_start_i);
    cmd = 5'h12;
    wt(40);
    cmd = 5'h10;
    wt(20);
    v = mop_setpoint_o;
    chk("up", 10'h001, 10'(v != 10'h000));
    tap(kp_stop_i);
    cmd = 5'h12;
    wt(40);
    chk("upstop", v, mop_setpoint_o);
    cmd = 5'h14;
    wt(20);
    chk("down", 10'h001, 10'(mop_setpoint_o < v));
    cmd = 5'h10;
    wt(20);
    v = mop_setpoint_o;
    wt(20);
    chk("hold", v, mop_setpoint_o);
    confirm(3);
    chk("keyoff", 10'h000, 10'(status_o.auto_state));
    am_mode_i = srs_pkg::SRS_AM_LOCAL_ONLY;
    confirm(3);
    chk("auto", 10'h001, 10'(status_o.auto_state));
    chk("kpref", 10'h000, 10'(ref_src_o));
    chk("coll2", 10'h001, 10'(collector_status_out_2_o));
    confirm(30);
    chk("late", 10'h001, 10'(status_o.auto_state));
    sel_cfg_i = 9'h040;
    cmd = 5'h14;
    wt(20);
    chk("vref", 10'h001, 10'(ref_src_o));
    remote_i = 1'h1;
    cmd = 5'h10;
    wt(20);
    confirm(3);
    chk("rkey", 10'h000, 10'(status_o.auto_state));
    am_mode_i = srs_pkg::SRS_AM_SPEED;
    wt(3);
    chk("rkp", 10'h008, 10'({status_o.auto_state, ref_src_o}));
    confirm(3);
    chk("rman", 10'h000, 10'({status_o.auto_state, ref_src_o}));
    cmd = 5'h14;
    wt(20);
    confirm(3);
    chk("rauto", 10'h009, 10'({status_o.auto_state, ref_src_o}));
    // Other indication choices and the opposite spans on both analog outputs
    relay_fn_i = srs_pkg::SRS_IND_STOPPED;
    coll1_fn_i = srs_pkg::SRS_IND_REMOTE;
    coll2_fn_i = srs_pkg::SRS_IND_REVERSE;
    freq_ofs_span_i = 1'h0;
    load_ofs_span_i = 1'h1;
    wt(3);
    chk("relay1", 10'h001, 10'(relay_contact_one_o));
    chk("coll1", 10'h001, 10'(collector_status_out_1_o));
    chk("coll2", 10'h000, 10'(collector_status_out_2_o));
    chk("freq", 10'h200, frequency_analog_out_o);
    chk("load", 10'h3FE, load_analog_out_o);
    complete_run();
  end
endmodule

//--- inc/srs_cfg.svh
// Timing, reset and scaling constants of the speed reference selector
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH

// ********************************************
// Clock and times
// ********************************************
`define SRS_CLK_HZ          40000000
`define SRS_CLK_KHZ         40000
`define SRS_AM_CONFIRM_MS   3000
`define SRS_DEBOUNCE_MS     10
`define SRS_MOP_STEP_MS     10

// ********************************************
// Widths and reset values
// ********************************************
`define SRS_LVL_W           10
`define SRS_MOP_RST         10'h000
`define SRS_MOP_MIN         10'h000
`define SRS_MOP_MAX         10'h3FF
`define SRS_AOUT_OFS        10'h0CD
`define SRS_AOUT_FS         10'h3FF

`endif

//--- inc/srs_pkg.sv
// Types shared by the speed reference selector files
package srs_pkg;

  // ********************************************
  // Select input functions
  // ********************************************
  typedef enum logic [2:0] {
    SRS_FN_NONE    = 3'h0,
    SRS_FN_VOLTS   = 3'h1,
    SRS_FN_CURRENT = 3'h2,
    SRS_FN_PRESET  = 3'h3,
    SRS_FN_DOWN    = 3'h4,
    SRS_FN_UP      = 3'h5,
    SRS_FN_REVERSE = 3'h6
  } srs_sel_fn_t;

  typedef enum logic [1:0] {
    SRS_AM_OFF        = 2'h0,
    SRS_AM_LOCAL_ONLY = 2'h1,
    SRS_AM_SPEED      = 2'h2
  } srs_am_mode_t;

  typedef enum logic [2:0] {
    SRS_SRC_KEYPAD  = 3'h0,
    SRS_SRC_VOLTS   = 3'h1,
    SRS_SRC_CURRENT = 3'h2,
    SRS_SRC_SP1     = 3'h3,
    SRS_SRC_SP2     = 3'h4,
    SRS_SRC_SP3     = 3'h5,
    SRS_SRC_SP4     = 3'h6
  } srs_src_t;

  typedef enum logic [2:0] {
    SRS_IND_OFF     = 3'h0,
    SRS_IND_RUN     = 3'h1,
    SRS_IND_AUTO    = 3'h2,
    SRS_IND_REVERSE = 3'h3,
    SRS_IND_REMOTE  = 3'h4,
    SRS_IND_FOLLOW  = 3'h5,
    SRS_IND_STOPPED = 3'h6
  } srs_ind_t;

  typedef enum logic [1:0] {
    SRS_AMS_IDLE = 2'b01,
    SRS_AMS_PEND = 2'b10
  } srs_am_state_t;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic run_stop;
    logic start;
    logic sel_a;
    logic sel_b;
    logic sel_c;
  } srs_contacts_t;

  typedef struct packed {
    srs_sel_fn_t fn_a;
    srs_sel_fn_t fn_b;
    srs_sel_fn_t fn_c;
  } srs_sel_cfg_t;

  typedef struct packed {
    logic running;
    logic reverse;
    logic auto_state;
    logic follow_auto;
    logic remote;
    logic mop_active;
  } srs_status_t;

endpackage

//--- src/srs_debounce.sv
// Three-stage synchroniser and debounce filter for one contact input
`timescale 1ns/10ps
module srs_debounce #(
  parameter int DEB_CYC = 400000
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic raw_i,
  output logic      level_o
);
  localparam int CW = $clog2(DEB_CYC + 1);

  initial
  begin
    if (DEB_CYC < 1)
      $error("srs_debounce: DEB_CYC must be at least 1");
  end

  logic          s1_r;
  logic          s2_r;
  logic          s3_r;
  logic          lvl_r;
  logic [CW-1:0] cnt_r;
  wire  logic    agree = (s2_r == s3_r);
  wire  logic    done  = (cnt_r == CW'(DEB_CYC - 1));

  // ********************************************
  // Sync chain; a level must hold DEB_CYC cycles
  // ********************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      s1_r <= raw_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (!agree || (s3_r == lvl_r))
        cnt_r <= '0;
      else if (done)
      begin
        lvl_r <= s3_r;
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_r + CW'(1);
    end
  end

  assign level_o = lvl_r;
endmodule

//--- src/srs_mop.sv
// Contact driven raise/lower speed setpoint
`timescale 1ns/10ps
`include "srs_cfg.svh"
module srs_mop #(
  parameter int STEP_CYC = 400000
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic                  down_i,
  input  wire logic                  up_i,
  output logic [`SRS_LVL_W-1:0]      setpoint_o,
  output logic                       active_o
);
  localparam int CW = $clog2(STEP_CYC + 1);

  initial
  begin
    if (STEP_CYC < 1)
      $error("srs_mop: STEP_CYC must be at least 1");
  end

  logic [CW-1:0]         pre_r;
  logic [`SRS_LVL_W-1:0] sp_r;
  wire  logic            tick   = (pre_r == CW'(STEP_CYC - 1));
  wire  logic            at_min = (sp_r <= `SRS_MOP_MIN);
  wire  logic            at_max = (sp_r >= `SRS_MOP_MAX);

  // ********************************************
  // Step the setpoint while a contact is closed
  // ********************************************
  // Lowering wins when both are closed, so a stuck raise cannot run away
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      pre_r <= '0;
      sp_r  <= `SRS_MOP_RST;
    end
    else
    begin
      pre_r <= (tick || !(down_i || up_i)) ? '0 : pre_r + CW'(1);
      if (tick && down_i && !at_min)
        sp_r <= sp_r - `SRS_LVL_W'(1);
      else if (tick && up_i && !down_i && !at_max)
        sp_r <= sp_r + `SRS_LVL_W'(1);
    end
  end

  assign setpoint_o = sp_r;
  assign active_o   = down_i || up_i;
endmodule

//--- src/srs_top.sv
// Speed reference selector: source choice, start/stop, status and analog outputs
`timescale 1ns/10ps
`include "srs_cfg.svh"
module srs_top #(
  parameter int DEB_CYC  = (`SRS_CLK_KHZ * `SRS_DEBOUNCE_MS),
  parameter int AM_CYC   = (`SRS_CLK_KHZ * `SRS_AM_CONFIRM_MS),
  parameter int STEP_CYC = (`SRS_CLK_KHZ * `SRS_MOP_STEP_MS)
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire srs_pkg::srs_contacts_t contacts_i,
  input  wire srs_pkg::srs_sel_cfg_t sel_cfg_i,
  input  wire srs_pkg::srs_am_mode_t am_mode_i,
  input  wire logic                  remote_i,
  input  wire logic                  three_wire_i,
  input  wire logic                  am_key_i,
  input  wire logic                  enter_key_i,
  input  wire logic                  kp_start_i,
  input  wire logic                  kp_stop_i,
  input  wire logic [`SRS_LVL_W-1:0] freq_level_i,
  input  wire logic [`SRS_LVL_W-1:0] load_level_i,
  input  wire logic                  freq_ofs_span_i,
  input  wire logic                  load_ofs_span_i,
  input  wire srs_pkg::srs_ind_t     relay_fn_i,
  input  wire srs_pkg::srs_ind_t     coll1_fn_i,
  input  wire srs_pkg::srs_ind_t     coll2_fn_i,
  output srs_pkg::srs_src_t          ref_src_o,
  output logic [`SRS_LVL_W-1:0]      mop_setpoint_o,
  output srs_pkg::srs_status_t       status_o,
  output logic [`SRS_LVL_W-1:0]      frequency_analog_out_o,
  output logic [`SRS_LVL_W-1:0]      load_analog_out_o,
  output logic                       relay_contact_one_o,
  output logic                       relay_contact_two_o,
  output logic                       collector_status_out_1_o,
  output logic                       collector_status_out_2_o
);
  localparam int W   = `SRS_LVL_W;
  localparam int AMW = $clog2(AM_CYC + 1);
  initial
  begin
    if (AM_CYC < 2)
      $error("srs_top: AM_CYC must be at least 2");
    if (W < 4)
      $error("srs_top: level width too small");
  end

  // ********************************************
  // Contact inputs
  // ********************************************
  srs_pkg::srs_contacts_t lvl;
  logic [4:0]             raw_vec;
  logic [4:0]             lvl_vec;
  assign raw_vec = contacts_i;
  assign lvl     = srs_pkg::srs_contacts_t'(lvl_vec);
  // One filter per contact, each closure read as a high level
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_deb
      srs_debounce #(
        .DEB_CYC (DEB_CYC)
      ) u_deb (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .raw_i     (raw_vec[gi]),
        .level_o   (lvl_vec[gi])
      );
    end
  endgenerate

  // ********************************************
  // Select input decoding
  // ********************************************
  function automatic logic fn_is_ref(input srs_pkg::srs_sel_fn_t fn);
    fn_is_ref = (fn == srs_pkg::SRS_FN_VOLTS) || (fn == srs_pkg::SRS_FN_CURRENT) ||
                (fn == srs_pkg::SRS_FN_PRESET);
  endfunction
  // Preset number is fixed by the terminal letter
  function automatic srs_pkg::srs_src_t fn_src(input srs_pkg::srs_sel_fn_t fn,
                                               input srs_pkg::srs_src_t preset);
    case (fn)
      srs_pkg::SRS_FN_VOLTS:   fn_src = srs_pkg::SRS_SRC_VOLTS;
      srs_pkg::SRS_FN_CURRENT: fn_src = srs_pkg::SRS_SRC_CURRENT;
      srs_pkg::SRS_FN_PRESET:  fn_src = preset;
      default:                 fn_src = srs_pkg::SRS_SRC_KEYPAD;
    endcase
  endfunction

  wire logic ref_a  = lvl.sel_a && fn_is_ref(sel_cfg_i.fn_a);
  wire logic ref_b  = lvl.sel_b && fn_is_ref(sel_cfg_i.fn_b);
  wire logic ref_c  = lvl.sel_c && fn_is_ref(sel_cfg_i.fn_c);
  wire logic pre_a  = ref_a && (sel_cfg_i.fn_a == srs_pkg::SRS_FN_PRESET);
  wire logic pre_b  = ref_b && (sel_cfg_i.fn_b == srs_pkg::SRS_FN_PRESET);
  wire logic pre_c  = ref_c && (sel_cfg_i.fn_c == srs_pkg::SRS_FN_PRESET);
  wire logic ref_any = ref_a || ref_b || ref_c;
  wire srs_pkg::srs_src_t src_a = fn_src(sel_cfg_i.fn_a, srs_pkg::SRS_SRC_SP1);
  wire srs_pkg::srs_src_t src_b = fn_src(sel_cfg_i.fn_b, srs_pkg::SRS_SRC_SP2);
  wire srs_pkg::srs_src_t src_c = fn_src(sel_cfg_i.fn_c, srs_pkg::SRS_SRC_SP3);
  // Two closed presets and no other closed reference input count as the fourth preset
  wire logic [1:0] n_ref   = {1'b0, ref_a} + {1'b0, ref_b} + {1'b0, ref_c};
  wire logic [1:0] n_pre   = {1'b0, pre_a} + {1'b0, pre_b} + {1'b0, pre_c};
  wire logic       pre_four = (n_ref == 2'h2) && (n_pre == 2'h2);
  wire srs_pkg::srs_src_t auto_src =
    pre_four ? srs_pkg::SRS_SRC_SP4 :
    ref_c    ? src_c :
    ref_b    ? src_b :
    ref_a    ? src_a : srs_pkg::SRS_SRC_KEYPAD;
  wire logic down_cmd = lvl.sel_a && (sel_cfg_i.fn_a == srs_pkg::SRS_FN_DOWN);
  wire logic up_cmd   = lvl.sel_b && (sel_cfg_i.fn_b == srs_pkg::SRS_FN_UP);
  wire logic rev_cmd  = lvl.sel_c && (sel_cfg_i.fn_c == srs_pkg::SRS_FN_REVERSE);

  // ********************************************
  // Start / stop
  // ********************************************
  logic start_q_r;
  logic rev_q_r;
  logic run_r;
  logic rev_r;
  logic run_nxt;
  logic rev_nxt;
  wire logic start_rise = lvl.start && !start_q_r;
  wire logic rev_rise   = rev_cmd && !rev_q_r;
  // Start and select terminals steer the run state only in remote; the keypad keys and the run/stop loop in local
  always_comb
  begin
    run_nxt = run_r;
    rev_nxt = rev_r;
    if (remote_i)
    begin
      if (!three_wire_i)
      begin
        run_nxt = lvl.run_stop && (lvl.start || rev_cmd);
        if (run_nxt && !run_r)
          rev_nxt = rev_cmd && !lvl.start;
      end
      else if (!lvl.run_stop)
        run_nxt = 1'b0;
      else if (start_rise)
      begin
        run_nxt = 1'b1;
        rev_nxt = 1'b0;
      end
      else if (rev_rise)
      begin
        run_nxt = 1'b1;
        rev_nxt = 1'b1;
      end
    end
    else
    begin
      // Keypad start still needs the run/stop loop closed
      if (kp_stop_i || !lvl.run_stop)
        run_nxt = 1'b0;
      else if (kp_start_i)
      begin
        run_nxt = 1'b1;
        rev_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      start_q_r <= 1'b0;
      rev_q_r   <= 1'b0;
      run_r     <= 1'b0;
      rev_r     <= 1'b0;
    end
    else
    begin
      start_q_r <= lvl.start;
      rev_q_r   <= rev_cmd;
      run_r     <= run_nxt;
      rev_r     <= rev_nxt;
    end
  end

  // ********************************************
  // Auto / manual keypad toggle with confirm window
  // ********************************************
  srs_pkg::srs_am_state_t am_st_r;
  srs_pkg::srs_am_state_t am_st_nxt;
  logic [AMW-1:0]         am_tmr_r;
  logic [AMW-1:0]         am_tmr_nxt;
  logic                   am_auto_r;
  logic                   am_auto_nxt;
  // Speed setting enables the key in both modes, local-only setting in local only
  wire logic key_en =
    (am_mode_i == srs_pkg::SRS_AM_SPEED) ||
    (!remote_i && (am_mode_i == srs_pkg::SRS_AM_LOCAL_ONLY));
  always_comb
  begin
    am_st_nxt   = am_st_r;
    am_tmr_nxt  = am_tmr_r;
    am_auto_nxt = am_auto_r;
    case (am_st_r)
      srs_pkg::SRS_AMS_IDLE:
      begin
        if (key_en && am_key_i)
        begin
          am_st_nxt  = srs_pkg::SRS_AMS_PEND;
          am_tmr_nxt = AMW'(AM_CYC - 1);
        end
      end
      srs_pkg::SRS_AMS_PEND:
      begin
        // A missed window or a lost key enable drops the pending change
        if (!key_en || (am_tmr_r == '0))
          am_st_nxt = srs_pkg::SRS_AMS_IDLE;
        else if (enter_key_i)
        begin
          am_st_nxt   = srs_pkg::SRS_AMS_IDLE;
          am_auto_nxt = !am_auto_r;
        end
        else
          am_tmr_nxt = am_tmr_r - AMW'(1);
      end
      default:
      begin
        am_st_nxt  = srs_pkg::SRS_AMS_IDLE;
        am_tmr_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      am_st_r   <= srs_pkg::SRS_AMS_IDLE;
      am_tmr_r  <= '0;
      am_auto_r <= 1'b0;
    end
    else
    begin
      am_st_r   <= am_st_nxt;
      am_tmr_r  <= am_tmr_nxt;
      am_auto_r <= am_auto_nxt;
    end
  end

  // ********************************************
  // Speed source
  // ********************************************
  // Without the key, remote auto state simply mirrors a closed reference input
  wire logic auto_state =
    key_en   ? am_auto_r :
    remote_i ? ref_any : 1'b0;
  // Auto with nothing closed stays auto but runs on keypad speed
  wire logic follow_auto = auto_state && ref_any;
  wire srs_pkg::srs_src_t src_nxt =
    follow_auto ? auto_src : srs_pkg::SRS_SRC_KEYPAD;

  // ********************************************
  // Raise / lower setpoint
  // ********************************************
  wire logic mop_active;
  srs_mop #(
    .STEP_CYC (STEP_CYC)
  ) u_mop (
    .clk_sys_i  (clk_sys_i),
    .nrst_i     (nrst_i),
    .down_i     (down_cmd),
    .up_i       (up_cmd && run_r),
    .setpoint_o (mop_setpoint_o),
    .active_o   (mop_active)
  );

  // ********************************************
  // Status and indication selection
  // ********************************************
  srs_pkg::srs_status_t st_nxt;
  assign st_nxt.running     = run_r;
  assign st_nxt.reverse     = rev_r;
  assign st_nxt.auto_state  = auto_state;
  assign st_nxt.follow_auto = follow_auto;
  assign st_nxt.remote      = remote_i;
  assign st_nxt.mop_active  = mop_active;

  function automatic logic ind_pick(input srs_pkg::srs_ind_t sel,
                                    input srs_pkg::srs_status_t st);
    case (sel)
      srs_pkg::SRS_IND_RUN:     ind_pick = st.running;
      srs_pkg::SRS_IND_AUTO:    ind_pick = st.auto_state;
      srs_pkg::SRS_IND_REVERSE: ind_pick = st.reverse;
      srs_pkg::SRS_IND_REMOTE:  ind_pick = st.remote;
      srs_pkg::SRS_IND_FOLLOW:  ind_pick = st.follow_auto;
      srs_pkg::SRS_IND_STOPPED: ind_pick = !st.running;
      default:                  ind_pick = 1'b0;
    endcase
  endfunction

  wire logic relay_nxt = ind_pick(relay_fn_i, st_nxt);
  wire logic coll1_nxt = ind_pick(coll1_fn_i, st_nxt);
  wire logic coll2_nxt = ind_pick(coll2_fn_i, st_nxt);

  // ********************************************
  // Analog outputs
  // ********************************************
  // Offset span maps full input range onto offset..one code below full scale; truncation
  // loses under one code, which is below the converter's own error
  localparam logic [W-1:0] SPAN = `SRS_AOUT_FS - `SRS_AOUT_OFS;

  wire logic [2*W-1:0] f_prod = freq_level_i * SPAN;
  wire logic [2*W-1:0] l_prod = load_level_i * SPAN;
  wire logic [W-1:0]   f_ofs  = `SRS_AOUT_OFS + f_prod[2*W-1:W];
  wire logic [W-1:0]   l_ofs  = `SRS_AOUT_OFS + l_prod[2*W-1:W];
  wire logic [W-1:0]   f_nxt  = freq_ofs_span_i ? f_ofs : freq_level_i;
  wire logic [W-1:0]   l_nxt  = load_ofs_span_i ? l_ofs : load_level_i;

  // ********************************************
  // Output registers
  // ********************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ref_src_o                <= srs_pkg::SRS_SRC_KEYPAD;
      status_o                 <= '0;
      frequency_analog_out_o   <= '0;
      load_analog_out_o        <= '0;
      relay_contact_one_o      <= 1'b0;
      relay_contact_two_o      <= 1'b1;
      collector_status_out_1_o <= 1'b0;
      collector_status_out_2_o <= 1'b0;
    end
    else
    begin
      ref_src_o                <= src_nxt;
      status_o                 <= st_nxt;
      frequency_analog_out_o   <= f_nxt;
      load_analog_out_o        <= l_nxt;
      relay_contact_one_o      <= relay_nxt;
      relay_contact_two_o      <= !relay_nxt;
      collector_status_out_1_o <= coll1_nxt;
      collector_status_out_2_o <= coll2_nxt;
    end
  end
endmodule
